// ==== pkg/vcpa_pkg.sv ====
// Constants for the channel resource capability and control registers.
package vcpa_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] CAP_OFF = 12'h110;
  localparam logic [11:0] CTL_OFF = 12'h114;
  localparam logic [11:0] STS_OFF = 12'h118;

  // ****************************************************************
  // Capability register fields
  // ****************************************************************
  localparam logic [7:0] ARB_CAP_VAL = 8'h03;
  localparam int ARB_CAP_FIXED_RR_BIT = 0;
  localparam int ARB_CAP_WRR32_BIT = 1;
  localparam int ADV_SW_BIT = 14;
  localparam logic ADV_SW_VAL = 1'h0;
  localparam int SNOOP_REJ_BIT = 15;
  localparam logic SNOOP_REJ_VAL = 1'h0;
  localparam int MAX_TS_LSB = 16;
  localparam logic [6:0] MAX_TS_VAL = 7'h00;
  localparam int TBL_OFFSET_LSB = 24;
  localparam logic [7:0] TBL_OFFSET_VAL = 8'h02;
  localparam logic [31:0] CAP_WORD = {TBL_OFFSET_VAL, 1'h0, MAX_TS_VAL, SNOOP_REJ_VAL,
                                      ADV_SW_VAL, 6'h00, ARB_CAP_VAL};

  // ****************************************************************
  // Control and status register fields
  // ****************************************************************
  localparam int TC_MAP_LSB = 0;
  localparam logic [7:0] TC_MAP_RST = 8'hFF;
  localparam logic [7:0] TC_MAP_WR_MASK = 8'hFE;
  localparam int LOAD_BIT = 16;
  localparam int SEL_LSB = 17;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam int VC_EN_BIT = 31;
  localparam logic VC_EN_VAL = 1'h1;
  localparam int TBL_STATUS_BIT = 0;

  typedef enum logic [2:0] {
    VCPA_SEL_FIXED_RR = 3'h0,
    VCPA_SEL_WRR32 = 3'h1
  } vcpa_sel_type;

endpackage

// ==== design/vcpa_sticky.sv ====
// Sticky flag where a set in the same cycle as a clear wins.
`timescale 1ns/1ps
module vcpa_sticky (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag_q
);
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (set_in) begin
      flag_d = 1'b1;
    end else if (clr_in) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      flag_q <= flag_d;
    end
  end
endmodule

// ==== design/vcpa_regs.sv ====
// Channel resource capability, control and status registers with table load request.
//
// Behaviour
// - Capability bits 7:0 read 0x3, two arbitration schemes supported.
// - Capability bit 0 means hardware fixed round robin, which is implemented.
// - Capability bit 1 means 32-phase weighted round robin; bits 2-5 unused.
// - Advanced switching capability bit 14 reads zero.
// - Snoop rejection capability bit 15 reads zero.
// - Maximum time slots bits 22:16 read zero.
// - Bits 31:24 read 0x2, table offset in 16-byte units.
// - Traffic class map resets to 0xFF; bit 0 fixed, bits 1-7 writable.
// - A set map bit routes that traffic class onto this channel.
// - Writing one to control bit 16 loads the table into arbitration logic.
// - The load acts only when the selected scheme uses the table.
// - Writing zero to the load bit does nothing.
// - The load bit always reads zero.
// - Table status sets on any table entry write, clears on load completion unless an entry write comes in the same cycle.
// - Select field bits 19:17 chooses scheme; legal values are capability bit positions.
`timescale 1ns/1ps
module vcpa_regs
  import vcpa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [11:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata_q,
  output logic cfg_rvalid_q,
  input wire logic tbl_entry_wr,
  input wire logic tbl_load_done,
  output logic [7:0] tc_map_q,
  output logic [2:0] arb_sel_q,
  output logic load_req_q,
  output logic tbl_status_q
);

  // ****************************************************************
  // Register write path
  // ****************************************************************
  logic [7:0] tc_map_d;
  logic [2:0] arb_sel_d;
  logic load_req_d;
  logic wr_ctl;
  logic [2:0] sel_wdata;

  assign wr_ctl = cfg_wr && (cfg_addr == CTL_OFF);
  assign sel_wdata = cfg_wdata[SEL_LSB +: 3];

  always_comb begin
    tc_map_d = tc_map_q;
    arb_sel_d = arb_sel_q;
    load_req_d = 1'b0;
    if (wr_ctl && cfg_be[0]) begin
      // Bit 0 stays set so traffic class 0 always uses this channel.
      tc_map_d = (cfg_wdata[7:0] & TC_MAP_WR_MASK) | ~TC_MAP_WR_MASK;
    end
    if (wr_ctl && cfg_be[2]) begin
      // Only values naming a supported scheme are accepted.
      if (sel_wdata < 3'h6 && ARB_CAP_VAL[sel_wdata]) begin
        arb_sel_d = sel_wdata;
      end
      // Only the fixed round robin scheme ignores the table. The scheme in force
      // before this write decides, so changing select and loading at once uses the old one.
      load_req_d = cfg_wdata[LOAD_BIT] && (arb_sel_q == VCPA_SEL_WRR32);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tc_map_q <= TC_MAP_RST;
      arb_sel_q <= SEL_RST;
      load_req_q <= 1'b0;
    end else if (ce) begin
      tc_map_q <= tc_map_d;
      arb_sel_q <= arb_sel_d;
      load_req_q <= load_req_d;
    end
  end

  // ****************************************************************
  // Table status
  // ****************************************************************
  // An entry write in the same cycle as a finished load leaves the flag set,
  // because the table then holds values the arbitration logic has not seen.
  vcpa_sticky u_tbl_status (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .set_in(tbl_entry_wr),
    .clr_in(tbl_load_done),
    .flag_q(tbl_status_q)
  );

  // ****************************************************************
  // Register read path
  // ****************************************************************
  logic [31:0] rdata_d;
  logic [31:0] ctl_word;

  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[7:0] = tc_map_q;
    ctl_word[LOAD_BIT] = 1'b0;
    ctl_word[SEL_LSB +: 3] = arb_sel_q;
    ctl_word[VC_EN_BIT] = VC_EN_VAL;
    rdata_d = 32'h0000_0000;
    case (cfg_addr)
      CAP_OFF: begin
        rdata_d = CAP_WORD;
      end
      CTL_OFF: begin
        rdata_d = ctl_word;
      end
      STS_OFF: begin
        rdata_d[TBL_STATUS_BIT] = tbl_status_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_rdata_q <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
    end else if (ce) begin
      // Read data is zero outside a read answer.
      cfg_rdata_q <= cfg_rd ? rdata_d : 32'h0000_0000;
      cfg_rvalid_q <= cfg_rd;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_arb_cap_bits: assert property (ce && cfg_rd && cfg_addr == CAP_OFF |=>
    cfg_rdata_q[7:0] == 8'h03) else $error("arbitration capability not 0x3");
  a_scheme_bits: assert property (ce && cfg_rd && cfg_addr == CAP_OFF |=>
    cfg_rdata_q[0] && cfg_rdata_q[1] && cfg_rdata_q[5:2] == 4'h0)
    else $error("scheme capability bits wrong");
  a_feature_bits: assert property (ce && cfg_rd && cfg_addr == CAP_OFF |=>
    cfg_rdata_q[15:8] == 8'h00 && cfg_rdata_q[23:16] == 8'h00)
    else $error("unsupported feature bits set");
  a_tbl_offset: assert property (ce && cfg_rd && cfg_addr == CAP_OFF |=>
    cfg_rdata_q[31:24] == 8'h02) else $error("table offset not 0x2");
  a_tc_bit0_fixed: assert property (tc_map_q[0] == 1'b1)
    else $error("traffic class 0 unmapped");
  a_load_pulse: assert property (ce && wr_ctl && cfg_be[2] && cfg_wdata[16] &&
    arb_sel_q == 3'h1 |=> load_req_q ##1 (!$past(ce) || !load_req_q || $past(wr_ctl)))
    else $error("load request not a single pulse");
  a_load_ignored: assert property (ce && wr_ctl && (arb_sel_q == 3'h0 ||
    !cfg_wdata[16]) |=> !load_req_q) else $error("load acted without table");
  a_load_reads0: assert property (ce && cfg_rd && cfg_addr == CTL_OFF |=>
    !cfg_rdata_q[16] && cfg_rdata_q[15:8] == 8'h00) else $error("load bit read as one");
  a_status_set: assert property (ce && tbl_entry_wr |=> tbl_status_q)
    else $error("table status not set by entry write");
  a_status_clear: assert property (ce && tbl_load_done && !tbl_entry_wr |=>
    !tbl_status_q) else $error("table status not cleared by load done");
  a_sel_legal: assert property (arb_sel_q == 3'h0 || arb_sel_q == 3'h1)
    else $error("illegal arbitration select");

  // ****************************************************************
  // Hold, accept and reject checks
  // ****************************************************************
  // Every piece of state but the load request, which falls back to zero, moves only on its own write or event strobe.
  a_sel_reject: assert property (ce && wr_ctl && cfg_be[2] &&
    cfg_wdata[19:17] > 3'h1 |=> $stable(arb_sel_q))
    else $error("unsupported arbitration select accepted");
  a_sel_accept: assert property (ce && wr_ctl && cfg_be[2] &&
    cfg_wdata[19:17] <= 3'h1 |=> {12'h000, arb_sel_q, 17'h00000} ==
    ($past(cfg_wdata) & 32'h000E_0000)) else $error("legal arbitration select not taken");
  a_sel_hold: assert property (!(ce && wr_ctl && cfg_be[2]) |=>
    $stable(arb_sel_q)) else $error("arbitration select changed without a write");
  a_map_write: assert property (ce && wr_ctl && cfg_be[0] |=>
    {24'h000000, tc_map_q} == (($past(cfg_wdata) & 32'h0000_00FE) | 32'h0000_0001))
    else $error("traffic class map write not applied");
  a_map_hold: assert property (!(ce && wr_ctl && cfg_be[0]) |=>
    $stable(tc_map_q)) else $error("traffic class map changed without a write");
  a_load_needs_write: assert property (ce && !(wr_ctl && cfg_be[2]) |=>
    !load_req_q) else $error("load request without a control write");
  a_status_hold: assert property (ce && !tbl_entry_wr && !tbl_load_done |=>
    $stable(tbl_status_q)) else $error("table status changed on its own");
  // A frozen cycle must leave every stored bit as it was.
  a_freeze_state: assert property (!ce |=>
    $stable(tc_map_q) && $stable(arb_sel_q) && $stable(load_req_q) && $stable(tbl_status_q))
    else $error("state moved while clock enable low");

  // ****************************************************************
  // Read path checks
  // ****************************************************************
  a_ctl_fixed_bits: assert property (ce && cfg_rd && cfg_addr == CTL_OFF |=>
    cfg_rdata_q[31] && cfg_rdata_q[30:20] == 11'h000)
    else $error("control register fixed bits wrong");
  a_status_read: assert property (ce && cfg_rd && cfg_addr == STS_OFF |=>
    cfg_rdata_q == {31'h0000_0000, $past(tbl_status_q)})
    else $error("status read does not match flag");
  a_unmapped_zero: assert property (ce && cfg_rd && cfg_addr != CAP_OFF &&
    cfg_addr != CTL_OFF && cfg_addr != STS_OFF |=> cfg_rdata_q == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Read data drops back to zero so a stale word is never taken as an answer.
  a_idle_rdata: assert property (ce && !cfg_rd |=>
    !cfg_rvalid_q && cfg_rdata_q == 32'h0000_0000) else $error("read data without a read");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  c_load_issued: cover property (ce && wr_ctl && cfg_wdata[16] ##1 load_req_q);
  c_sel_wrr: cover property (arb_sel_q == 3'h1 ##1 ce && tbl_load_done);
  c_set_clear_same: cover property (ce && tbl_entry_wr && tbl_load_done);
  c_tc_unmapped: cover property (tc_map_q != 8'hFF);
  c_frozen_write: cover property (!ce && wr_ctl);
endmodule

// ==== verif/tb.sv ====
// Self-checking testbench for the channel resource register bank.
`timescale 1ns/1ps
module tb
  import vcpa_pkg::*;
;
  logic ref_clk = 1'h0, srst = 1'h1, ce = 1'h1, cfg_wr = 1'h0, cfg_rd = 1'h0;
  logic tbl_entry_wr = 1'h0, tbl_load_done = 1'h0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata_q;
  logic cfg_rvalid_q, load_req_q, tbl_status_q;
  logic [7:0] tc_map_q;
  logic [2:0] arb_sel_q;
  int n_mismatch = 0, tests_run = 0;

  vcpa_regs DUT (.ref_clk(ref_clk), .srst(srst), .ce(ce), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rvalid_q(cfg_rvalid_q), .tbl_entry_wr(tbl_entry_wr), .tbl_load_done(tbl_load_done),
    .tc_map_q(tc_map_q), .arb_sel_q(arb_sel_q), .load_req_q(load_req_q),
    .tbl_status_q(tbl_status_q));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic summarize();
    $display("counts: %0d compared, %0d wrong", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The read answer stands one cycle after the taking edge.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    cfg_addr = a;
    cfg_rd = 1'h1;
    @(negedge ref_clk);
    cfg_rd = 1'h0;
    chk({31'h0, cfg_rvalid_q}, 32'h1);
    chk(cfg_rdata_q, exp);
    @(negedge ref_clk);
    chk({31'h0, cfg_rvalid_q}, 32'h0);
    chk(cfg_rdata_q, 32'h0);
  endtask

  // Checks the load request in the cycle after the write and its drop one cycle later.
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d,
                    input logic exp_load);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = 1'h1;
    @(negedge ref_clk);
    cfg_wr = 1'h0;
    chk({31'h0, load_req_q}, {31'h0, exp_load});
    @(negedge ref_clk);
    chk({31'h0, load_req_q}, 32'h0);
  endtask

  task automatic pulse(input logic e, input logic d, input logic exp);
    tbl_entry_wr = e;
    tbl_load_done = d;
    @(negedge ref_clk);
    tbl_entry_wr = 1'h0;
    tbl_load_done = 1'h0;
    chk({31'h0, tbl_status_q}, {31'h0, exp});
    @(negedge ref_clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk({24'h0, tc_map_q}, 32'h000000FF);
    chk({29'h0, arb_sel_q}, 32'h0);
    rd(CAP_OFF, 32'h02000003);
    rd(CTL_OFF, 32'h800000FF);
    rd(STS_OFF, 32'h0);
    rd(12'h11C, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_ctl();
    wr(CAP_OFF, 4'hF, 32'hFFFFFFFF, 1'h0);
    rd(CAP_OFF, 32'h02000003);
    wr(CTL_OFF, 4'hF, 32'h0002FF54, 1'h0);
    rd(CTL_OFF, 32'h80020055);
    chk({24'h0, tc_map_q}, 32'h00000055);
    wr(CTL_OFF, 4'hF, 32'h000E00AA, 1'h0);
    rd(CTL_OFF, 32'h800200AB);
    wr(CTL_OFF, 4'h4, 32'h00060000, 1'h0);
    rd(CTL_OFF, 32'h800200AB);
    wr(CTL_OFF, 4'h1, 32'h00000000, 1'h0);
    rd(CTL_OFF, 32'h80020001);
    $display("test control done");
  endtask

  task automatic t_load();
    wr(CTL_OFF, 4'hF, 32'h000300FF, 1'h1);
    rd(CTL_OFF, 32'h800200FF);
    wr(CTL_OFF, 4'hF, 32'h000200FF, 1'h0);
    wr(CTL_OFF, 4'hF, 32'h000100FF, 1'h1);
    chk({29'h0, arb_sel_q}, 32'h0);
    wr(CTL_OFF, 4'hF, 32'h000100FF, 1'h0);
    $display("test load done");
  endtask

  task automatic t_status();
    pulse(1'h1, 1'h0, 1'h1);
    rd(STS_OFF, 32'h1);
    pulse(1'h0, 1'h0, 1'h1);
    pulse(1'h1, 1'h1, 1'h1);
    pulse(1'h0, 1'h1, 1'h0);
    rd(STS_OFF, 32'h0);
    $display("test status done");
  endtask

  // A frozen write must change nothing; a mid-run reset restores every field.
  task automatic t_hold();
    ce = 1'h0;
    cfg_addr = CTL_OFF;
    cfg_be = 4'hF;
    cfg_wdata = 32'h000300AA;
    cfg_wr = 1'h1;
    tbl_entry_wr = 1'h1;
    @(negedge ref_clk);
    cfg_wr = 1'h0;
    tbl_entry_wr = 1'h0;
    @(negedge ref_clk);
    chk({24'h0, tc_map_q}, 32'h000000FF);
    chk({29'h0, arb_sel_q}, 32'h0);
    chk({31'h0, load_req_q}, 32'h0);
    chk({31'h0, tbl_status_q}, 32'h0);
    ce = 1'h1;
    wr(CTL_OFF, 4'hF, 32'h00020010, 1'h0);
    pulse(1'h1, 1'h0, 1'h1);
    srst = 1'h1;
    repeat (2) @(negedge ref_clk);
    srst = 1'h0;
    chk({24'h0, tc_map_q}, 32'h000000FF);
    chk({29'h0, arb_sel_q}, 32'h0);
    chk({31'h0, tbl_status_q}, 32'h0);
    rd(CTL_OFF, 32'h800000FF);
    $display("test hold and reset done");
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (2) @(negedge ref_clk);
    srst = 1'h0;
    t_reset();
    t_ctl();
    t_load();
    t_status();
    t_hold();
    summarize();
  end
endmodule
